// file: verilog/scd_sysclk_reset.sv
`timescale 1ns/100ps

module scd_sysclk_reset (
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   input  wire logic                       ext_rst_n_pin,
   input  wire logic                       lrck_pin,
   output logic                            ready,
   output logic                            init_busy,
   output logic                            mode_load,
   output logic [scd_pkg::MODE_W-1:0]      mode_q,
   output scd_pkg::scd_ratio_t             ratio_code,
   output logic                            ratio_valid
);
   import scd_pkg::*;

   logic [1:0]        rst_sync_q;
   logic [1:0]        lrck_sync_q;
   logic              lrck_prev_q;
   logic              ext_rst_s;
   logic              lrck_s;
   logic              lrck_rise;
   scd_state_t        state_q;
   logic [INIT_W-1:0] init_cnt_q;
   logic [PER_W-1:0]  per_cnt_q;
   logic              per_seen_q;
   scd_ratio_t        ratio_d;

   // nearest documented ratio within tolerance, else bad
   function automatic scd_ratio_t classify(input logic [10:0] n);
      scd_ratio_t r;
      r = RATIO_BAD;
      if (n >= 11'h080 - PER_TOL && n <= 11'h080 + PER_TOL) r = RATIO_128;
      if (n >= 11'h0C0 - PER_TOL && n <= 11'h0C0 + PER_TOL) r = RATIO_192;
      if (n >= 11'h100 - PER_TOL && n <= 11'h100 + PER_TOL) r = RATIO_256;
      if (n >= 11'h180 - PER_TOL && n <= 11'h180 + PER_TOL) r = RATIO_384;
      if (n >= 11'h200 - PER_TOL && n <= 11'h200 + PER_TOL) r = RATIO_512;
      if (n >= 11'h300 - PER_TOL && n <= 11'h300 + PER_TOL) r = RATIO_768;
      return r;
   endfunction : classify

   // pin synchronisers, system clock domain only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q  <= 2'b00;
         lrck_sync_q <= 2'b00;
         lrck_prev_q <= 1'b0;
      end else begin
         rst_sync_q  <= {rst_sync_q[0], ext_rst_n_pin};
         lrck_sync_q <= {lrck_sync_q[0], lrck_pin};
         lrck_prev_q <= lrck_sync_q[1];
      end
   end

   assign ext_rst_s = rst_sync_q[1];
   assign lrck_s    = lrck_sync_q[1];
   assign lrck_rise = lrck_s && !lrck_prev_q;

   // sequencer: hold, initialize, run
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q    <= ST_HOLD;
         init_cnt_q <= '0;
      end else if (!ext_rst_s) begin
         state_q    <= ST_HOLD;
         init_cnt_q <= '0;
      end else begin
         case (state_q)
            ST_HOLD: begin
               state_q    <= ST_INIT;
               init_cnt_q <= '0;
            end
            ST_INIT: begin
               if (init_cnt_q == INIT_LAST) begin
                  state_q <= ST_RUN;
               end
               init_cnt_q <= init_cnt_q + INIT_W'(1);
            end
            ST_RUN: begin
               state_q <= ST_RUN;
            end
            default: begin
               state_q    <= ST_HOLD;
               init_cnt_q <= '0;
            end
         endcase
      end
   end

   // status outputs from flops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ready     <= 1'b0;
         init_busy <= 1'b0;
         mode_load <= 1'b0;
      end else begin
         ready     <= ext_rst_s && ((state_q == ST_RUN) ||
                      (state_q == ST_INIT && init_cnt_q == INIT_LAST));
         init_busy <= ext_rst_s && (state_q == ST_HOLD ||
                      (state_q == ST_INIT && init_cnt_q != INIT_LAST));
         mode_load <= ext_rst_s && state_q == ST_INIT && init_cnt_q == INIT_LAST;
      end
   end

   // mode control word, defaults loaded at end of initialization
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= MODE_DEFAULT;
      end else if (!ext_rst_s) begin
         mode_q <= MODE_DEFAULT;
      end else if (state_q == ST_INIT && init_cnt_q == INIT_LAST) begin
         mode_q <= MODE_DEFAULT;
      end
   end

   // clocks per sample period, measured between word clock rises
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         per_cnt_q  <= '0;
         per_seen_q <= 1'b0;
      end else if (lrck_rise) begin
         per_cnt_q  <= 11'h001;
         per_seen_q <= 1'b1;
      end else if (per_cnt_q != PER_MAX) begin
         per_cnt_q  <= per_cnt_q + PER_W'(1);
      end
   end

   assign ratio_d = classify(per_cnt_q);

   // latch ratio at each period end, no configuration needed
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ratio_code  <= RATIO_BAD;
         ratio_valid <= 1'b0;
      end else if (lrck_rise && per_seen_q) begin
         ratio_code  <= ratio_d;
         ratio_valid <= (ratio_d != RATIO_BAD);
      end else if (per_cnt_q == PER_MAX) begin
         ratio_code  <= RATIO_BAD;              // word clock stopped
         ratio_valid <= 1'b0;
      end
   end

   // checks
   sequence s_release;
      state_q == ST_HOLD && ext_rst_s;
   endsequence

   sequence s_counting;
      state_q == ST_INIT [*8];
   endsequence

   // a fresh external reset may cut the count short at any time
   chk_init_start: assert property (@(posedge core_clk) disable iff (!resetn || !ext_rst_s)
      s_release |=> s_counting)
      else $error("initialization did not start after reset release");

   chk_init_end: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_q == ST_INIT && init_cnt_q == INIT_LAST && ext_rst_s) |=> state_q == ST_RUN)
      else $error("initialization did not end after 1024 clocks");

   chk_no_early_run: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_q == ST_INIT && init_cnt_q != INIT_LAST) |=> state_q != ST_RUN)
      else $error("run entered before initialization finished");

   chk_default_load: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_q == ST_INIT && init_cnt_q == INIT_LAST && ext_rst_s)
      |=> mode_load && ready && mode_q == MODE_DEFAULT)
      else $error("defaults not loaded at end of initialization");

   chk_hold_reset: assert property (@(posedge core_clk) disable iff (!resetn)
      !ext_rst_s |=> state_q == ST_HOLD && init_cnt_q == '0)
      else $error("state not held during external reset");

   chk_reset_default: assert property (@(posedge core_clk) disable iff (!resetn)
      !ext_rst_s |=> !ready ##1 mode_q == MODE_DEFAULT)
      else $error("external reset did not restore default state");

   chk_run_stable: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_q == ST_RUN && ext_rst_s) |=> state_q == ST_RUN && !mode_load)
      else $error("run state left without reset");

   chk_ratio_valid: assert property (@(posedge core_clk) disable iff (!resetn)
      (lrck_rise && per_seen_q && per_cnt_q >= 11'h0FE && per_cnt_q <= 11'h102)
      |=> ratio_valid && ratio_code == RATIO_256)
      else $error("256x ratio not recognised");

   chk_ratio_bad: assert property (@(posedge core_clk) disable iff (!resetn)
      (lrck_rise && per_seen_q && per_cnt_q > 11'h302) |=> !ratio_valid && ratio_code == RATIO_BAD)
      else $error("unknown ratio reported valid");

   chk_ratio_768: assert property (@(posedge core_clk) disable iff (!resetn)
      (lrck_rise && per_seen_q && per_cnt_q >= 11'h2FE && per_cnt_q <= 11'h302)
      |=> ratio_valid && ratio_code == RATIO_768)
      else $error("768x ratio not recognised");

   chk_first_period: assert property (@(posedge core_clk) disable iff (!resetn)
      (lrck_rise && !per_seen_q) |=> !ratio_valid)
      else $error("partial first period reported valid");

   // load pulse, then ready held with the pulse gone
   sequence s_load_end;
      mode_load && ready ##1 !mode_load && ready;
   endsequence

   chk_load_pulse: assert property (@(posedge core_clk) disable iff (!resetn || !ext_rst_s)
      (state_q == ST_INIT && init_cnt_q == INIT_LAST) |=> s_load_end)
      else $error("default load not a single pulse");

   chk_hold_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
      !ext_rst_s |=> !init_busy && !mode_load)
      else $error("busy or load shown during external reset");

   chk_busy_init: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_q == ST_INIT && init_cnt_q != INIT_LAST && ext_rst_s) |=> init_busy && !ready)
      else $error("busy not shown while initializing");

endmodule : scd_sysclk_reset

// file: verilog/scd_pkg.sv
package scd_pkg;

   // initialization sequence length in system clocks
   localparam int          INIT_CYCLES = 1024;
   localparam int          INIT_W      = $clog2(INIT_CYCLES);
   localparam logic [9:0]  INIT_LAST   = 10'(INIT_CYCLES - 1);

   // period counter for ratio detection, saturating
   localparam int          PER_W       = 11;
   localparam logic [10:0] PER_MAX     = 11'h7FF;
   localparam logic [10:0] PER_TOL     = 11'h002;   // accepted jitter, clocks

   // mode control word and its default value
   localparam int          MODE_W       = 16;
   localparam logic [15:0] MODE_DEFAULT = 16'h0000;

   // detected clock ratio codes
   typedef enum logic [2:0] {
      RATIO_128 = 3'b000,
      RATIO_192 = 3'b001,
      RATIO_256 = 3'b010,
      RATIO_384 = 3'b011,
      RATIO_512 = 3'b100,
      RATIO_768 = 3'b101,
      RATIO_BAD = 3'b111
   } scd_ratio_t;

   // sequencer states
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_INIT = 2'b01,
      ST_RUN  = 2'b10
   } scd_state_t;

endpackage : scd_pkg

// file: testbench/scd_src_model.sv
`timescale 1ns/100ps

module scd_src_model (
   input  wire logic        core_clk,
   input  wire logic [11:0] per,
   input  wire logic        rst_go,
   input  wire logic [7:0]  rst_len,
   output logic             lrck_pin,
   output logic             ext_rst_n_pin
);
   logic [11:0] cnt;
   logic [7:0]  rcnt;

   initial begin
      lrck_pin      = 1'b0;
      ext_rst_n_pin = 1'b1;
      cnt           = 12'h000;
      rcnt          = 8'h00;
   end

   // word clock, per clocks a sample, first half high; listed ratios used with jitter, plus an unlisted 1000
   always @(posedge core_clk) begin
      cnt      <= (cnt + 12'h001 >= per) ? 12'h000 : cnt + 12'h001;
      lrck_pin <= (cnt + 12'h001 >= per) ? 1'b1 : (cnt + 12'h001 < (per >> 1));
   end

   // reset pin held low rst_len clocks, always after clock runs
   always @(posedge core_clk) begin
      if (rst_go) begin
         ext_rst_n_pin <= 1'b0;
         rcnt          <= rst_len;
      end else if (rcnt > 8'h01) begin
         rcnt <= rcnt - 8'h01;
      end else begin
         rcnt          <= 8'h00;
         ext_rst_n_pin <= 1'b1;
      end
   end
endmodule : scd_src_model

// file: testbench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
   import scd_pkg::*;
   logic        core_clk, resetn, rst_go, lrck_pin, ext_rst_n_pin;
   logic        ready, init_busy, mode_load, ratio_valid;
   logic [15:0] mode_q;
   scd_ratio_t  ratio_code;
   logic [11:0] per;
   logic [7:0]  rst_len;
   int          err_count, checks_done, cyc;
   int          ratios[$] = '{128, 192, 256, 384, 512, 768, 1000};

   scd_src_model src (.core_clk(core_clk), .per(per), .rst_go(rst_go), .rst_len(rst_len),
      .lrck_pin(lrck_pin), .ext_rst_n_pin(ext_rst_n_pin));
   scd_sysclk_reset uut (.core_clk(core_clk), .resetn(resetn), .ext_rst_n_pin(ext_rst_n_pin),
      .lrck_pin(lrck_pin), .ready(ready), .init_busy(init_busy), .mode_load(mode_load),
      .mode_q(mode_q), .ratio_code(ratio_code), .ratio_valid(ratio_valid));

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         give_verdict();
      end
   end

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task give_verdict();
      if (err_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   // count busy clocks until ready, then check defaults and pulse
   task wait_init();
      int n, b;
      n = 0;
      b = 0;
      while (ready !== 1'b1 && n < 2200) begin
         @(posedge core_clk);
         #1;
         if (b > 0 && ready !== 1'b1) chk("busy_gap", 16'(init_busy), 16'h0001);
         if (init_busy === 1'b1) b++;
         chk("ready_early", 16'(ready === 1'b1 && b < INIT_CYCLES), 16'h0000);
         n++;
      end
      chk("init_len", 16'(b), 16'(INIT_CYCLES));
      chk("mode_load", 16'(mode_load), 16'h0001);
      chk("mode_q", mode_q, MODE_DEFAULT);
      @(posedge core_clk);
      #1;
      chk("mode_load_end", 16'(mode_load), 16'h0000);
   endtask : wait_init

   task pulse_rst();
      @(posedge core_clk);
      rst_len <= 8'(3 + $urandom % 60);
      rst_go  <= 1'b1;
      @(posedge core_clk);
      rst_go  <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      chk("ready_rst", 16'(ready), 16'h0000);
      chk("busy_rst", 16'(init_busy), 16'h0000);
   endtask : pulse_rst

   // main sequence, reference codes from the ratio queue index
   initial begin
      void'($urandom(32'h30CF));
      resetn = 1'b0;
      rst_go = 1'b0;
      per = 12'h100;
      rst_len = 8'h03;
      cyc = 0;
      err_count = 0;
      checks_done = 0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      wait_init();
      foreach (ratios[i]) begin
         @(posedge core_clk);
         per <= 12'(ratios[i] + int'($urandom % 3) - 1);
         repeat (4) @(posedge lrck_pin);
         repeat (5) @(posedge core_clk);
         #1;
         chk("ratio_code", 16'(ratio_code), (i < 6) ? 16'(i) : 16'h0007);
         chk("ratio_valid", 16'(ratio_valid), 16'(i < 6));
      end
      pulse_rst();
      wait_init();
      pulse_rst();
      repeat (300) @(posedge core_clk);
      pulse_rst();
      wait_init();
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("mode_q_por", mode_q, MODE_DEFAULT);
      chk("ready_por", 16'(ready), 16'h0000);
      @(posedge core_clk);
      resetn <= 1'b1;
      wait_init();
      give_verdict();
   end
endmodule : tb_top
